// ### src/lpe_edit_core.sv
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// What this block does
// - search program memory for a given instruction or a bit address operand
// - search starts at the address after the displayed one, or at zero after clear
// - each further search press finds the next occurrence of same target
// - searching indication shown while a search runs
// - down key on a found multiword instruction shows its next word
// - outside program mode the displayed bit shows its on/off state
// - insert and delete only in program mode, refused in run or monitor
// - entry word, insert, down places new instruction before displayed one
// - delete then up removes every word of the displayed instruction
// - later words shift after insert or delete, addresses stay contiguous
// - no undo copy; deleted words are gone
// - a line executes through its rightmost instruction before the branch
// - eight temporary condition bits, numbered zero to seven
// - output to a temporary bit stores the condition, condition unchanged
// - load from a temporary bit restores the saved condition
// - load sets condition from bit; and combines by logical and
// - and-not combines condition with the inverted operand bit
module lpe_edit_core import lpe_pkg::*; #(
	parameter int AW = 8,
	parameter int IOW = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic searching_indication_o
);

	localparam int LW = AW + 1;
	localparam int IW = $clog2(IOW);
	localparam logic [LW-1:0] DEPTH = LW'(1 << AW);

	typedef struct packed {
		lpe_state_e state;
		logic [1:0] mode;
		logic [LW-1:0] len;
		logic [AW-1:0] disp;
		logic [15:0] word;
		logic cleared;
		logic [1:0] contact_key_left;
		logic [15:0] target;
		logic bit_mode;
		logic shift_prev;
		logic contact_armed;
		logic searching;
		logic found;
		logic not_found;
		logic [LW-1:0] ptr;
		logic [1:0] skip;
		logic rejected;
		logic ins_armed;
		logic del_armed;
		logic [1:0] ins_more;
		logic [15:0] ins_word;
		logic [AW-1:0] ins_at;
		logic [2:0] del_n;
		logic [IOW-1:0] io;
		logic [7:0] tr;
		logic cond;
		logic blk;
		logic bit_valid;
		logic bit_state;
		logic ack;
		logic [31:0] dat;
	} lpe_core_s;

	lpe_core_s r;
	lpe_core_s next_r;
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic acc;
	logic wr;
	logic key_go;
	logic [3:0] key;
	logic [15:0] entry;
	logic [3:0] ev_op;
	logic ev_tr;
	logic ev_bit;
	logic [2:0] del_eff;

	lpe_mem #(.AW(AW), .DW(16)) u_mem (
		.clk_i(clk_i),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdata),
		.rdata_o(mem_rdata)
	);

	// operand value: temporary bit or io relay bit
	function automatic logic op_bit(input logic [15:0] w, input logic [7:0] tr,
		input logic [IOW-1:0] io);
		op_bit = w[OPERAND_TR_BIT] ? tr[w[2:0]] : io[w[IW-1:0]];
	endfunction

	assign acc = wb_cyc_i && wb_stb_i && r.ack;
	assign wr = acc && wb_we_i;
	assign key_go = wr && (wb_adr_i == REG_KEY) && wb_sel_i[0] && (r.state == ST_IDLE);
	assign key = wb_dat_i[3:0];
	assign entry = wb_dat_i[KEY_ENTRY_LSB +: 16];
	assign ev_op = mem_rdata[15:12];
	assign ev_tr = mem_rdata[OPERAND_TR_BIT];
	assign ev_bit = op_bit(mem_rdata, r.tr, r.io);
	assign del_eff = ({1'b0, r.disp} + LW'(lpe_words(r.word)) > r.len)
		? 3'(r.len - {1'b0, r.disp}) : lpe_words(r.word);

	// ==========================================================
	// next state
	always_comb
	begin
		next_r = r;
		mem_we = 1'b0;
		mem_addr = '0;
		mem_wdata = '0;
		next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
		if (next_r.ack)
		begin
			unique case (wb_adr_i)
				REG_CTRL: next_r.dat = {30'h0, r.mode};
				REG_STATUS: next_r.dat = {7'h0, r.len, 5'h0, r.bit_state, r.bit_valid,
					r.cleared, r.del_armed, r.ins_armed, (r.len == DEPTH), r.rejected,
					r.not_found, r.found, (r.state != ST_IDLE), r.searching};
				REG_DISP: next_r.dat = {16'(r.disp), r.word};
				REG_IO: next_r.dat = 32'(r.io);
				REG_EVAL: next_r.dat = {23'h0, r.cond, r.tr};
				default: next_r.dat = 32'h0;
			endcase
		end
		if (wr && wb_adr_i == REG_CTRL)
		begin
			if (wb_sel_i[0])
			begin
				next_r.mode = wb_dat_i[1:0];
			end
			if (wb_sel_i[1] && wb_dat_i[CTRL_EVAL_BIT] && r.state == ST_IDLE)
			begin
				next_r.ptr = '0;
				next_r.cond = 1'b0;
				next_r.blk = 1'b0;
				next_r.state = ST_EV_RD;
			end
		end
		if (wr && wb_adr_i == REG_IO)
		begin
			for (int b = 0; b < IOW / 8; b++)
			begin
				if (wb_sel_i[b])
				begin
					next_r.io[b*8 +: 8] = wb_dat_i[b*8 +: 8];
				end
			end
		end
		// live bit status beside the displayed word
		next_r.bit_valid = (r.mode != MODE_PROG) && !r.cleared && lpe_has_bit(r.word);
		next_r.bit_state = next_r.bit_valid && op_bit(r.word, r.tr, r.io);
		if (key_go)
		begin
			next_r.rejected = 1'b0;
			next_r.not_found = 1'b0;
			next_r.shift_prev = (key == KEY_SHIFT);
			next_r.ins_armed = 1'b0;
			next_r.del_armed = 1'b0;
			if (key != KEY_CONTACT && key != KEY_SEARCH)
			begin
				next_r.contact_armed = 1'b0;
			end
			unique case (key)
				KEY_CONTACT: next_r.contact_armed = r.shift_prev;
				KEY_SEARCH:
				begin
					if (wb_dat_i[KEY_NEW_BIT])
					begin
						next_r.target = entry;
						next_r.bit_mode = r.contact_armed;
					end
					next_r.contact_armed = 1'b0;
					next_r.searching = 1'b1;
					next_r.found = 1'b0;
					next_r.ptr = r.cleared ? '0 : {1'b0, r.disp} + LW'(1);
					next_r.skip = r.cleared ? 2'h0 : r.contact_key_left;
					next_r.state = ST_SR_RD;
				end
				KEY_CLEAR:
				begin
					next_r.cleared = 1'b1;
					next_r.found = 1'b0;
					next_r.disp = '0;
					next_r.contact_key_left = 2'h0;
				end
				KEY_ENTER:
				begin
					if (r.mode != MODE_PROG)
					begin
						next_r.rejected = 1'b1;
					end
					else if (r.ins_more != 2'h0)
					begin
						// further operand words of an inserted instruction
						if (r.len == DEPTH)
						begin
							next_r.rejected = 1'b1;
						end
						else
						begin
							next_r.ins_word = entry;
							next_r.ins_at = r.disp + 1'b1;
							next_r.ins_more = r.ins_more - 2'h1;
							next_r.ptr = r.len;
							next_r.state = ST_INS_RD;
						end
					end
					else if ({1'b0, r.disp} < r.len || ({1'b0, r.disp} == r.len && r.len != DEPTH))
					begin
						mem_we = 1'b1;
						mem_addr = r.disp;
						mem_wdata = entry;
						next_r.word = entry;
						next_r.cleared = 1'b0;
						next_r.contact_key_left = 2'h0;
						if ({1'b0, r.disp} == r.len)
						begin
							next_r.len = r.len + LW'(1);
						end
					end
					else
					begin
						next_r.rejected = 1'b1;
					end
				end
				KEY_INSERT:
				begin
					next_r.ins_armed = (r.mode == MODE_PROG);
					next_r.rejected = (r.mode != MODE_PROG);
					next_r.ins_word = entry;
					next_r.ins_more = 2'h0;
				end
				KEY_DELETE:
				begin
					next_r.del_armed = (r.mode == MODE_PROG) && !r.cleared
						&& ({1'b0, r.disp} < r.len);
					next_r.rejected = (r.mode != MODE_PROG);
				end
				KEY_DOWN:
				begin
					if (r.ins_armed && r.mode == MODE_PROG)
					begin
						if (r.len == DEPTH)
						begin
							next_r.rejected = 1'b1;
						end
						else
						begin
							next_r.ins_at = r.disp;
							next_r.ins_more = 2'(lpe_words(r.ins_word) - 3'h1);
							next_r.ptr = r.len;
							next_r.state = ST_INS_RD;
						end
					end
					// may step onto the free slot just past the end, where enter appends
					else if ({1'b0, r.disp} < r.len && {1'b0, r.disp} + LW'(1) < DEPTH)
					begin
						next_r.disp = r.cleared ? '0 : r.disp + 1'b1;
						next_r.contact_key_left = r.cleared ? 2'h0 : r.contact_key_left;
						next_r.state = ST_DISP_RD;
					end
				end
				KEY_UP:
				begin
					if (r.del_armed && r.mode == MODE_PROG)
					begin
						next_r.del_n = del_eff;
						next_r.ptr = {1'b0, r.disp} + LW'(del_eff);
						next_r.state = ST_DEL_RD;
					end
					else if (r.disp != '0 && !r.cleared)
					begin
						next_r.disp = r.disp - 1'b1;
						next_r.contact_key_left = 2'h0;
						next_r.state = ST_DISP_RD;
					end
				end
				default: ;
			endcase
		end
		unique case (r.state)
			ST_IDLE: ;
			ST_DISP_RD:
			begin
				mem_addr = r.disp;
				next_r.state = ST_DISP_LD;
			end
			ST_DISP_LD:
			begin
				// the slot past the end holds no word yet
				next_r.word = ({1'b0, r.disp} < r.len) ? mem_rdata : 16'h0000;
				next_r.cleared = 1'b0;
				next_r.contact_key_left = (r.contact_key_left != 2'h0) ? r.contact_key_left - 2'h1
					: 2'(lpe_words(next_r.word) - 3'h1);
				next_r.state = ST_IDLE;
			end
			ST_SR_RD:
			begin
				if (r.ptr >= r.len)
				begin
					next_r.searching = 1'b0;
					next_r.not_found = 1'b1;
					next_r.state = ST_IDLE;
				end
				else
				begin
					mem_addr = AW'(r.ptr);
					next_r.state = ST_SR_CHK;
				end
			end
			ST_SR_CHK:
			begin
				next_r.ptr = r.ptr + LW'(1);
				next_r.state = ST_SR_RD;
				if (r.skip != 2'h0)
				begin
					next_r.skip = r.skip - 2'h1;
				end
				else if (r.bit_mode ? (lpe_has_bit(mem_rdata)
					&& mem_rdata[11:0] == r.target[11:0]) : (mem_rdata == r.target))
				begin
					next_r.disp = AW'(r.ptr);
					next_r.word = mem_rdata;
					next_r.cleared = 1'b0;
					next_r.contact_key_left = 2'(lpe_words(mem_rdata) - 3'h1);
					next_r.found = 1'b1;
					next_r.searching = 1'b0;
					next_r.ptr = r.ptr;
					next_r.state = ST_IDLE;
				end
				else
				begin
					next_r.skip = 2'(lpe_words(mem_rdata) - 3'h1);
				end
			end
			ST_INS_RD:
			begin
				// move words up from the top, one read and one write each
				if (r.ptr > {1'b0, r.ins_at})
				begin
					mem_addr = AW'(r.ptr - LW'(1));
					next_r.state = ST_INS_WR;
				end
				else
				begin
					next_r.state = ST_INS_NEW;
				end
			end
			ST_INS_WR:
			begin
				mem_we = 1'b1;
				mem_addr = AW'(r.ptr);
				mem_wdata = mem_rdata;
				next_r.ptr = r.ptr - LW'(1);
				next_r.state = ST_INS_RD;
			end
			ST_INS_NEW:
			begin
				mem_we = 1'b1;
				mem_addr = r.ins_at;
				mem_wdata = r.ins_word;
				next_r.len = r.len + LW'(1);
				next_r.disp = r.ins_at;
				next_r.word = r.ins_word;
				next_r.cleared = 1'b0;
				next_r.contact_key_left = 2'h0;
				next_r.state = ST_IDLE;
			end
			ST_DEL_RD:
			begin
				if (r.ptr < r.len)
				begin
					mem_addr = AW'(r.ptr);
					next_r.state = ST_DEL_WR;
				end
				else
				begin
					// words are overwritten in place, nothing kept aside
					next_r.len = r.len - LW'(r.del_n);
					next_r.contact_key_left = 2'h0;
					next_r.found = 1'b0;
					if ({1'b0, r.disp} < r.len - LW'(r.del_n))
					begin
						next_r.state = ST_DISP_RD;
					end
					else
					begin
						next_r.cleared = 1'b1;
						next_r.state = ST_IDLE;
					end
				end
			end
			ST_DEL_WR:
			begin
				mem_we = 1'b1;
				mem_addr = AW'(r.ptr - LW'(r.del_n));
				mem_wdata = mem_rdata;
				next_r.ptr = r.ptr + LW'(1);
				next_r.state = ST_DEL_RD;
			end
			ST_EV_RD:
			begin
				if (r.ptr >= r.len)
				begin
					next_r.state = ST_IDLE;
				end
				else
				begin
					mem_addr = AW'(r.ptr);
					next_r.state = ST_EV_EX;
				end
			end
			ST_EV_EX:
			begin
				// strictly in address order: a line ends before its branch
				next_r.ptr = r.ptr + LW'(lpe_words(mem_rdata));
				next_r.state = ST_EV_RD;
				unique case (ev_op)
					OP_LD:
					begin
						next_r.blk = r.cond;
						next_r.cond = ev_bit;
					end
					OP_AND: next_r.cond = r.cond & ev_bit;
					OP_ANDNOT: next_r.cond = r.cond & ~ev_bit;
					OP_OUT:
					begin
						if (ev_tr)
						begin
							next_r.tr[mem_rdata[2:0]] = r.cond;
						end
						else
						begin
							next_r.io[mem_rdata[IW-1:0]] = r.cond;
						end
					end
					OP_ORLD: next_r.cond = r.cond | r.blk;
					OP_END: next_r.state = ST_IDLE;
					default: ;
				endcase
			end
			default: next_r.state = ST_IDLE;
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.state <= ST_IDLE;
			r.mode <= MODE_RESET;
			r.cleared <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign searching_indication_o = r.searching;

	// ==========================================================
	// checks
	sequence s_req;
		wb_cyc_i && wb_stb_i && !r.ack;
	endsequence

	sequence s_ins_commit;
		key_go && key == KEY_DOWN && r.ins_armed && r.mode == MODE_PROG;
	endsequence

	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	a_search_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.state == ST_SR_RD || r.state == ST_SR_CHK) |-> searching_indication_o)
		else $error("search running without indication");
	a_search_origin: assert property (@(posedge clk_i) disable iff (rst_i)
		key_go && key == KEY_SEARCH |=> r.state == ST_SR_RD
		&& r.ptr == ($past(r.cleared) ? '0 : {1'b0, $past(r.disp)} + LW'(1)))
		else $error("search started at wrong address");
	a_find_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_SR_CHK && next_r.found |=> r.found && !r.searching
		&& r.disp == AW'($past(r.ptr)) && r.word == $past(mem_rdata))
		else $error("found word not displayed");
	a_mode_guard: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_IDLE && (next_r.state == ST_INS_RD || next_r.state == ST_DEL_RD)
		|-> r.mode == MODE_PROG)
		else $error("edit started outside program mode");
	a_full_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
		s_ins_commit and (r.len == DEPTH) |=> r.state == ST_IDLE && r.rejected
		&& r.len == $past(r.len))
		else $error("insert into full memory not refused");
	a_insert_len: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_INS_NEW |=> r.len == $past(r.len) + LW'(1)
		&& r.word == $past(r.ins_word) && r.disp == $past(r.ins_at))
		else $error("insert did not grow program by one");
	a_delete_len: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_DEL_RD && r.ptr >= r.len |=> r.len == $past(r.len) - LW'($past(r.del_n)))
		else $error("delete removed wrong word count");
	a_tr_store: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_EV_EX && ev_op == OP_OUT && ev_tr
		|=> r.tr[$past(mem_rdata[2:0])] == $past(r.cond) && r.cond == $past(r.cond))
		else $error("temporary bit store wrong");
	a_tr_load: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_EV_EX && ev_op == OP_LD && ev_tr |=> r.cond == $past(ev_bit))
		else $error("temporary bit not restored");
	a_and_not: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_EV_EX && ev_op == OP_ANDNOT |=> r.cond == ($past(r.cond) && !$past(ev_bit)))
		else $error("and-not result wrong");

endmodule

// ### src/lpe_pkg.sv
package lpe_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_KEY = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_DISP = 8'h0C;
	localparam logic [7:0] REG_IO = 8'h10;
	localparam logic [7:0] REG_EVAL = 8'h14;

	// ==========================================================
	// field positions
	localparam int CTRL_EVAL_BIT = 8;
	localparam int KEY_NEW_BIT = 4;
	localparam int KEY_ENTRY_LSB = 16;
	localparam int DISP_ADDR_LSB = 16;
	localparam int STAT_LEN_LSB = 16;
	localparam int EVAL_COND_BIT = 8;
	localparam int OPERAND_TR_BIT = 11;

	// ==========================================================
	// operating modes, reset value first
	localparam logic [1:0] MODE_PROG = 2'h0;
	localparam logic [1:0] MODE_MON = 2'h1;
	localparam logic [1:0] MODE_RUN = 2'h2;
	localparam logic [1:0] MODE_RESET = MODE_PROG;

	// ==========================================================
	// console key codes
	localparam logic [3:0] KEY_ENTER = 4'h0;
	localparam logic [3:0] KEY_SEARCH = 4'h1;
	localparam logic [3:0] KEY_SHIFT = 4'h2;
	localparam logic [3:0] KEY_CONTACT = 4'h3;
	localparam logic [3:0] KEY_CLEAR = 4'h4;
	localparam logic [3:0] KEY_INSERT = 4'h5;
	localparam logic [3:0] KEY_DELETE = 4'h6;
	localparam logic [3:0] KEY_DOWN = 4'h7;
	localparam logic [3:0] KEY_UP = 4'h8;

	// ==========================================================
	// instruction word opcodes, bits 15:12
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_LD = 4'h1;
	localparam logic [3:0] OP_AND = 4'h2;
	localparam logic [3:0] OP_ANDNOT = 4'h3;
	localparam logic [3:0] OP_OUT = 4'h4;
	localparam logic [3:0] OP_ORLD = 4'h5;
	localparam logic [3:0] OP_WIDE = 4'h7;
	localparam logic [3:0] OP_END = 4'hF;

	typedef enum logic [3:0] {
		ST_IDLE, ST_DISP_RD, ST_DISP_LD, ST_SR_RD, ST_SR_CHK, ST_INS_RD, ST_INS_WR,
		ST_INS_NEW, ST_DEL_RD, ST_DEL_WR, ST_EV_RD, ST_EV_EX
	} lpe_state_e;

	// words taken by an instruction whose first word is w
	function automatic logic [2:0] lpe_words(input logic [15:0] w);
		lpe_words = (w[15:12] == OP_WIDE) ? 3'h1 + {1'b0, w[1:0]} : 3'h1;
	endfunction

	function automatic logic lpe_has_bit(input logic [15:0] w);
		lpe_has_bit = (w[15:12] == OP_LD) || (w[15:12] == OP_AND)
			|| (w[15:12] == OP_ANDNOT) || (w[15:12] == OP_OUT);
	endfunction

endpackage

// ### src/lpe_mem.sv
`timescale 1ns/1ps
module lpe_mem #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] store [1 << AW];

	// read data registered; write and read share one port
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			store[addr_i] <= wdata_i;
		end
		rdata_o <= store[addr_i];
	end

endmodule

// ### testbench/lpe_console.sv
`timescale 1ns/1ps
module lpe_console import lpe_pkg::*; (
	input wire logic clk_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o
);
	int hang = 0;

	initial
	begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'hF;
		wb_dat_o = 32'h0;
	end

	// ==========================================================
	// bus cycle, held until ack
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= adr;
		wb_dat_o <= dat;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_i !== 1'b1 && n < 64);
		if (wb_ack_i !== 1'b1)
			hang++;
		rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// released lines carry no stale value
		wb_adr_o <= ~adr;
		wb_dat_o <= ~dat;
		@(posedge clk_i);
	endtask

	// ==========================================================
	// keypad
	task automatic idle();
		logic [31:0] rd;
		int n;
		n = 0;
		do
		begin
			xfer(1'b0, REG_STATUS, 32'h0, rd);
			n++;
		end
		while (rd[1] !== 1'b0 && n < 300);
		if (rd[1] !== 1'b0)
			hang++;
	endtask

	task automatic press(input logic [3:0] code, input logic newt, input logic [15:0] entry);
		logic [31:0] rd;
		xfer(1'b1, REG_KEY, {entry, 11'h0, newt, code}, rd);
		idle();
	endtask

	task automatic bit_search(input logic [11:0] bit_adr);
		press(KEY_SHIFT, 1'b0, 16'h0);
		press(KEY_CONTACT, 1'b0, 16'h0);
		press(KEY_SEARCH, 1'b1, {4'h0, bit_adr});
	endtask
endmodule

// ### testbench/ladder_program_edit_and_branch_store_test.sv
`timescale 1ns/1ps
module ladder_program_edit_and_branch_store_test import lpe_pkg::*; ();
	localparam logic [31:0] LEN = 32'h01FF_0000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc, wb_stb, wb_we, wb_ack, searching;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, rd;
	logic saw_search_key = 1'b0;
	int num_errors = 0;
	int tests_run = 0;
	logic [15:0] prog [8] = '{16'h1000, 16'h4800, 16'h2001, 16'h4008,
		16'h1800, 16'h3002, 16'h4009, 16'hF000};
	logic [31:0] io_in [2] = '{32'h0000_0001, 32'h0000_0007};
	logic [31:0] io_out [2] = '{32'h0000_0201, 32'h0000_0107};
	logic [31:0] ev [2] = '{32'h0000_0101, 32'h0000_0001};

	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		if (searching === 1'b1)
			saw_search_key <= 1'b1;

	always @(posedge clk_i)
		if (lpe_console_i.hang != 0)
			close_out();

	lpe_edit_core #(.AW(8), .IOW(16)) lpe_edit_core_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat_r),
		.searching_indication_o(searching));

	lpe_console lpe_console_i (.clk_i(clk_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_dat_r),
		.wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
		.wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w));

	// ==========================================================
	// helpers
	task automatic close_out();
		num_errors = num_errors + lpe_console_i.hang;
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd_reg(input logic [7:0] adr);
		lpe_console_i.xfer(1'b0, adr, 32'h0, rd);
	endtask

	task automatic wr_reg(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] unused;
		lpe_console_i.xfer(1'b1, adr, dat, unused);
	endtask

	task automatic key(input logic [3:0] c, input logic n, input logic [15:0] e);
		lpe_console_i.press(c, n, e);
	endtask

	task automatic find(input logic [15:0] w);
		key(KEY_CLEAR, 1'b0, 16'h0);
		key(KEY_SEARCH, 1'b1, w);
		rd_reg(REG_DISP);
	endtask

	function automatic logic [31:0] dsp(input logic [7:0] a, input logic [15:0] w);
		return {8'h00, a, w};
	endfunction

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rd_reg(REG_CTRL);
		chk(rd, 32'h0);
		rd_reg(REG_STATUS);
		chk(rd, 32'h0000_0100);
		rd_reg(REG_EVAL);
		chk(rd, 32'h0);
		rd_reg(REG_IO);
		chk(rd, 32'h0);
		rd_reg(8'h18);
		chk(rd, 32'h0);
	endtask

	task automatic t_load();
		key(KEY_CLEAR, 1'b0, 16'h0);
		foreach (prog[i])
		begin
			key(KEY_ENTER, 1'b0, prog[i]);
			if (i < 7)
				key(KEY_DOWN, 1'b0, 16'h0);
		end
		rd_reg(REG_STATUS);
		chk(rd & LEN, 32'h0008_0000);
	endtask

	task automatic t_eval();
		for (int i = 0; i < 2; i++)
		begin
			wr_reg(REG_IO, io_in[i]);
			wr_reg(REG_CTRL, 32'h0000_0100);
			lpe_console_i.idle();
			rd_reg(REG_IO);
			chk(rd, io_out[i]);
			rd_reg(REG_EVAL);
			chk(rd, ev[i]);
		end
	endtask

	task automatic t_search();
		key(KEY_CLEAR, 1'b0, 16'h0);
		saw_search_key = 1'b0;
		lpe_console_i.bit_search(12'h800);
		rd_reg(REG_DISP);
		chk(rd, dsp(8'h01, 16'h4800));
		chk({31'h0, saw_search_key}, 32'h1);
		key(KEY_SEARCH, 1'b0, 16'h0);
		rd_reg(REG_DISP);
		chk(rd, dsp(8'h04, 16'h1800));
		key(KEY_SEARCH, 1'b0, 16'h0);
		rd_reg(REG_STATUS);
		chk(rd & 32'h8, 32'h8);
		find(16'h3002);
		chk(rd, dsp(8'h05, 16'h3002));
		key(KEY_SEARCH, 1'b1, 16'h1000);
		rd_reg(REG_STATUS);
		chk(rd & 32'h8, 32'h8);
	endtask

	task automatic t_edit();
		find(16'h3002);
		key(KEY_INSERT, 1'b0, 16'h2003);
		key(KEY_DOWN, 1'b0, 16'h0);
		rd_reg(REG_STATUS);
		chk(rd & LEN, 32'h0009_0000);
		find(16'h2003);
		chk(rd, dsp(8'h05, 16'h2003));
		find(16'h3002);
		chk(rd, dsp(8'h06, 16'h3002));
		find(16'h2003);
		key(KEY_DELETE, 1'b0, 16'h0);
		key(KEY_UP, 1'b0, 16'h0);
		rd_reg(REG_STATUS);
		chk(rd & LEN, 32'h0008_0000);
		find(16'h2003);
		rd_reg(REG_STATUS);
		chk(rd & 32'h8, 32'h8);
		find(16'h3002);
		chk(rd, dsp(8'h05, 16'h3002));
		// two-word instruction: insert, step through, delete whole
		key(KEY_INSERT, 1'b0, 16'h7001);
		key(KEY_DOWN, 1'b0, 16'h0);
		key(KEY_ENTER, 1'b0, 16'h0ABC);
		rd_reg(REG_STATUS);
		chk(rd & LEN, 32'h000A_0000);
		find(16'h7001);
		chk(rd, dsp(8'h05, 16'h7001));
		key(KEY_DOWN, 1'b0, 16'h0);
		rd_reg(REG_DISP);
		chk(rd, dsp(8'h06, 16'h0ABC));
		key(KEY_SEARCH, 1'b0, 16'h0);
		rd_reg(REG_STATUS);
		chk(rd & 32'h8, 32'h8);
		find(16'h7001);
		key(KEY_DELETE, 1'b0, 16'h0);
		key(KEY_UP, 1'b0, 16'h0);
		rd_reg(REG_STATUS);
		chk(rd & LEN, 32'h0008_0000);
		find(16'h3002);
		chk(rd, dsp(8'h05, 16'h3002));
	endtask

	task automatic t_mode();
		for (int i = 0; i < 2; i++)
		begin
			wr_reg(REG_CTRL, {30'h0, (i == 0) ? MODE_RUN : MODE_MON});
			find(16'h1000);
			rd_reg(REG_STATUS);
			chk(rd & 32'h600, 32'h600);
			key(KEY_INSERT, 1'b0, 16'h2003);
			rd_reg(REG_STATUS);
			chk(rd & 32'h10, 32'h10);
			key(KEY_DOWN, 1'b0, 16'h0);
			key(KEY_DELETE, 1'b0, 16'h0);
			rd_reg(REG_STATUS);
			chk(rd & 32'h10, 32'h10);
			key(KEY_UP, 1'b0, 16'h0);
			rd_reg(REG_STATUS);
			chk(rd & LEN, 32'h0008_0000);
		end
		wr_reg(REG_CTRL, {30'h0, MODE_PROG});
	endtask

	task automatic t_full();
		find(16'hF000);
		chk(rd, dsp(8'h07, 16'hF000));
		key(KEY_DOWN, 1'b0, 16'h0);
		for (int i = 8; i < 256; i++)
		begin
			key(KEY_ENTER, 1'b0, 16'h0000);
			if (i < 255)
				key(KEY_DOWN, 1'b0, 16'h0);
		end
		find(16'h3002);
		key(KEY_INSERT, 1'b0, 16'h2003);
		key(KEY_DOWN, 1'b0, 16'h0);
		rd_reg(REG_STATUS);
		chk(rd & 32'h01FF_0030, 32'h0100_0030);
		find(16'h3002);
		chk(rd, dsp(8'h05, 16'h3002));
	endtask

	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_load();
		t_eval();
		t_search();
		t_edit();
		t_mode();
		t_full();
		close_out();
	end
endmodule
